// ---- scm_clk_gen.sv ----
`timescale 1ns/1ps
module scm_clk_gen
    import scm_pkg::*;
#(
    parameter int DIV_W = BAUD_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Settings from the register file
    input wire logic [1:0] clk_sel,
    input wire logic sync_mode,
    input wire logic run,
    input wire logic [DIV_W-1:0] baud_div,
    // Serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // Timing pulses toward the shifters
    output logic tick16,
    output logic sclk_rise,
    output logic sclk_fall
);

    typedef struct packed {
        logic sck_meta;
        logic sck_sync;
        logic sck_prev;
        logic [DIV_W-1:0] div_cnt;
        logic [TICK_W-1:0] phase;
        logic tick;
        logic rise;
        logic fall;
        logic out;
    } scm_clk_state_t;

    scm_clk_state_t s;
    scm_clk_state_t n;
    logic ext;

    // Pin is driven only for the two codes that output a clock
    function automatic logic pin_drives(input logic [1:0] sel, input logic sync);
        pin_drives = sync ? (sel == CKS_INT) : (sel == CKS_INT_OUT);
    endfunction

    assign ext = (clk_sel == CKS_EXT);
    assign sck_oe = pin_drives(clk_sel, sync_mode);
    assign sck_out = s.out;
    assign tick16 = s.tick;
    assign sclk_rise = s.rise;
    assign sclk_fall = s.fall;

    // Divider, phase counter and external edge detection
    always_comb
    begin
        n = s;
        n.sck_meta = sck_in;
        n.sck_sync = s.sck_meta;
        n.sck_prev = s.sck_sync;
        n.tick = 1'b0;
        n.rise = 1'b0;
        n.fall = 1'b0;
        if (ext)
        begin
            // External clock is 16x bit rate in async, bit clock in sync
            n.tick = s.sck_sync && !s.sck_prev;
            n.rise = sync_mode && s.sck_sync && !s.sck_prev;
            n.fall = sync_mode && !s.sck_sync && s.sck_prev;
            n.div_cnt = '0;
            n.phase = '0;
            n.out = 1'b1;
        end
        else if (!run)
        begin
            // Idle clock rests high so the first bit starts on a falling edge
            n.div_cnt = '0;
            n.phase = '0;
            n.out = 1'b1;
        end
        else
        begin
            if (s.div_cnt == baud_div)
            begin
                n.div_cnt = '0;
                n.tick = 1'b1;
                n.phase = s.phase + 4'h1;
                n.rise = sync_mode && (s.phase == TICK_MID);
                n.fall = sync_mode && (s.phase == TICK_LAST);
            end
            else
            begin
                n.div_cnt = s.div_cnt + 1'b1;
            end
            n.out = n.phase[TICK_W-1];
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.sck_meta <= 1'b1;
            s.sck_sync <= 1'b1;
            s.sck_prev <= 1'b1;
            s.out <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

endmodule

// ---- scm_pkg.sv ----
package scm_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_TXD = 8'h0C;
    localparam logic [7:0] OFF_RXD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_ISTAT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1C;

    // serial_control field positions
    localparam int CTRL_CKS_LO = 0;
    localparam int CTRL_CKS_HI = 1;
    localparam int CTRL_TX_END_IRQ_EN = 2;
    localparam int CTRL_FILT = 3;
    localparam int CTRL_RXEN = 4;
    localparam int CTRL_TXEN = 5;

    // serial_mode_reg field positions
    localparam int MODE_SYNC = 0;
    localparam int MODE_MP = 1;

    // serial_status_reg field positions
    localparam int STAT_RXFULL = 0;
    localparam int STAT_FER = 1;
    localparam int STAT_OER = 2;
    localparam int STAT_TXEMPTY = 3;
    localparam int STAT_TXEND = 4;
    localparam int STAT_MPB = 5;

    // Interrupt status and mask bits
    localparam int IRQ_RXFULL = 0;
    localparam int IRQ_TXEMPTY = 1;
    localparam int IRQ_TXEND = 2;
    localparam int IRQ_RXERR = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_TXEND_MASK = 4'h4;
    localparam logic [7:0] IRQ_VECTOR = 8'h17;

    // Clock source select codes
    localparam logic [1:0] CKS_INT = 2'h0;
    localparam logic [1:0] CKS_INT_OUT = 2'h1;
    localparam logic [1:0] CKS_EXT = 2'h2;
    localparam logic [1:0] CKS_RSVD = 2'h3;

    // Widths, frame shape and reset values
    localparam int BAUD_W = 16;
    localparam int TXD_W = 9;
    localparam int RXD_MP_BIT = 8;
    localparam int TICK_W = 4;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] FRAME_PLAIN = 4'hA;
    localparam logic [3:0] FRAME_MP = 4'hB;

    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } scm_rx_state_t;

endpackage

// ---- scm_remote_station.sv ----
`timescale 1ns/1ps
module scm_remote_station
(
    // Clock
    input wire logic clk,
    // Serial link toward the unit
    output logic rxd,
    input wire logic txd,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in,
    // External clock request from the bench
    input wire logic ext_en
);
    logic ext_clk = 1'b1;

    // Pin level: unit drives when enabled, else our source; pull-up while idle
    assign pin_in = pin_oe ? pin_out : (ext_en ? ext_clk : 1'b1);

    // External source stands still unless asked to run
    always @(posedge clk)
        ext_clk <= ext_en ? ~ext_clk : 1'b1;

    initial rxd = 1'b1;

    // One async frame, 16 clocks a bit at divisor 0, mp bit only when asked
    task automatic send(input logic [7:0] d, input logic mp, input logic use_mp);
        logic [10:0] f;
        int n;
        f = {1'b1, mp, d, 1'b0};
        n = use_mp ? 11 : 10;
        for (int i = 0; i < n; i++)
        begin
            if (!use_mp && i == 9)
                f[i] = 1'b1;
            @(posedge clk);
            rxd <= f[i];
            repeat (15) @(posedge clk);
        end
    endtask

    // Capture one frame from the unit, sampling near mid-bit
    task automatic recv(output logic [7:0] d);
        int k;
        k = 0;
        while (txd !== 1'b0 && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge clk);
            d[i] = txd;
        end
    endtask
endmodule

// ---- scm_serial_ctrl.sv ----
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module scm_serial_ctrl
    import scm_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    input wire logic rxd,
    output logic txd,
    input wire logic serial_clk_pin_in,
    output logic serial_clk_pin_out,
    output logic serial_clk_pin_oe,
    // Interrupt
    output logic irq,
    output logic [7:0] irq_vector
);

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic filt;
        logic tx_end_irq_en;
        logic [1:0] clk_sel;
        logic sync_mode;
        logic mp_mode;
        logic [BAUD_W-1:0] baud_div;
        logic [TXD_W-1:0] tx_hold;
        logic tx_empty;
        logic tx_end;
        logic tx_busy;
        logic [10:0] tx_shift;
        logic [3:0] tx_cnt;
        logic [3:0] tx_tick;
        logic rx_meta;
        logic rx_sync;
        scm_rx_state_t rx_state;
        logic [3:0] rx_tick;
        logic [3:0] rx_cnt;
        logic [8:0] rx_shift;
        logic [8:0] rx_data;
        logic rx_full;
        logic framing_err_flag;
        logic overrun_err_flag;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
    } scm_state_t;

    scm_state_t s;
    scm_state_t n;
    logic tick16, sclk_rise, sclk_fall;
    logic setup, access, filt_act, step, frame_done, frame_mp, frame_ferr;
    logic [7:0] frame_data;
    logic [8:0] rx_next;
    logic [3:0] rx_last;
    logic [IRQ_W-1:0] ev, irq_en;
    logic [31:0] rd_word;
    logic [3:0] ctrl_wr_field;

    // Address decode for the error answer; read mux and write path decode by their own case
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == OFF_CTRL) || (a == OFF_MODE) || (a == OFF_BAUD) ||
            (a == OFF_TXD) || (a == OFF_RXD) || (a == OFF_STAT) ||
            (a == OFF_ISTAT) || (a == OFF_IMASK);
    endfunction

    scm_clk_gen #(.DIV_W(BAUD_W)) u_clk (
        .clk(clk),
        .rst(rst),
        .clk_sel(s.clk_sel),
        .sync_mode(s.sync_mode),
        .run(s.sync_mode ? s.tx_busy : 1'b1),
        .baud_div(s.baud_div),
        .sck_in(serial_clk_pin_in),
        .sck_out(serial_clk_pin_out),
        .sck_oe(serial_clk_pin_oe),
        .tick16(tick16),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall)
    );

    // Zero-wait APB: read data is captured in the setup cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign pslverr = access && !reg_hit(paddr);
    assign prdata = s.prdata;
    assign txd = s.tx_shift[0];
    assign irq_vector = IRQ_VECTOR;
    assign filt_act = s.filt && s.mp_mode && !s.sync_mode;
    assign ctrl_wr_field = {pwdata[CTRL_FILT], pwdata[CTRL_TX_END_IRQ_EN],
        pwdata[CTRL_CKS_HI], pwdata[CTRL_CKS_LO]};

    // Transmit-end source is additionally gated by its own enable
    always_comb
    begin
        irq_en = s.irq_mask;
        irq_en[IRQ_TXEND] = s.irq_mask[IRQ_TXEND] && s.tx_end_irq_en;
    end
    assign irq = |(s.irq_stat & irq_en);

    // Read multiplexer; unmapped addresses read as zero
    always_comb
    begin
        rd_word = '0;
        unique case (paddr)
            OFF_CTRL:
            begin
                rd_word[CTRL_TXEN] = s.tx_en;
                rd_word[CTRL_RXEN] = s.rx_en;
                rd_word[CTRL_FILT] = s.filt;
                rd_word[CTRL_TX_END_IRQ_EN] = s.tx_end_irq_en;
                rd_word[CTRL_CKS_HI] = s.clk_sel[1];
                rd_word[CTRL_CKS_LO] = s.clk_sel[0];
            end
            OFF_MODE:
            begin
                rd_word[MODE_SYNC] = s.sync_mode;
                rd_word[MODE_MP] = s.mp_mode;
            end
            OFF_BAUD: rd_word[BAUD_W-1:0] = s.baud_div;
            OFF_TXD: rd_word[TXD_W-1:0] = s.tx_hold;
            OFF_RXD: rd_word[RXD_MP_BIT:0] = s.rx_data;
            OFF_STAT:
            begin
                rd_word[STAT_RXFULL] = s.rx_full;
                rd_word[STAT_FER] = s.framing_err_flag;
                rd_word[STAT_OER] = s.overrun_err_flag;
                rd_word[STAT_TXEMPTY] = s.tx_empty;
                rd_word[STAT_TXEND] = s.tx_end;
                rd_word[STAT_MPB] = s.rx_data[RXD_MP_BIT];
            end
            OFF_ISTAT: rd_word[IRQ_W-1:0] = s.irq_stat;
            OFF_IMASK: rd_word[IRQ_W-1:0] = s.irq_mask;
            default: rd_word = '0;
        endcase
    end

    // Next state: bus effects first, so hardware events win over clears
    always_comb
    begin
        n = s;
        ev = '0;
        frame_done = 1'b0;
        frame_data = '0;
        frame_mp = 1'b0;
        frame_ferr = 1'b0;
        step = 1'b0;
        rx_next = {s.rx_sync, s.rx_shift[8:1]};
        rx_last = (s.sync_mode || !s.mp_mode) ? (DATA_BITS - 4'h1) : DATA_BITS;
        n.rx_meta = rxd;
        n.rx_sync = s.rx_meta;
        if (setup)
            n.prdata = rd_word;
        if (access && pwrite)
        begin
            unique case (paddr)
                OFF_CTRL:
                begin
                    n.tx_en = pwdata[CTRL_TXEN];
                    n.rx_en = pwdata[CTRL_RXEN];
                    n.filt = pwdata[CTRL_FILT];
                    n.tx_end_irq_en = pwdata[CTRL_TX_END_IRQ_EN];
                    n.clk_sel = {pwdata[CTRL_CKS_HI], pwdata[CTRL_CKS_LO]};
                end
                OFF_MODE:
                begin
                    n.sync_mode = pwdata[MODE_SYNC];
                    n.mp_mode = pwdata[MODE_MP];
                end
                OFF_BAUD: n.baud_div = pwdata[BAUD_W-1:0];
                OFF_TXD:
                begin
                    // A write while the holding register is full is dropped
                    if (s.tx_empty)
                    begin
                        n.tx_hold = pwdata[TXD_W-1:0];
                        n.tx_empty = 1'b0;
                        n.tx_end = 1'b0;
                    end
                end
                OFF_STAT:
                begin
                    n.framing_err_flag = s.framing_err_flag && !pwdata[STAT_FER];
                    n.overrun_err_flag = s.overrun_err_flag && !pwdata[STAT_OER];
                end
                OFF_IMASK: n.irq_mask = pwdata[IRQ_W-1:0];
                default: n.irq_mask = s.irq_mask;
            endcase
        end
        if (access && !pwrite && paddr == OFF_RXD)
            n.rx_full = 1'b0;
        if (access && !pwrite && paddr == OFF_ISTAT)
            n.irq_stat = '0;

        // Transmitter: move holding register into the shifter
        if (!s.tx_busy && !s.tx_empty && s.tx_en)
        begin
            n.tx_busy = 1'b1;
            n.tx_empty = 1'b1;
            n.tx_tick = '0;
            ev[IRQ_TXEMPTY] = 1'b1;
            if (s.sync_mode)
            begin
                n.tx_shift = {3'h7, s.tx_hold[7:0]};
                n.tx_cnt = DATA_BITS;
            end
            else
            begin
                n.tx_shift = {1'b1, s.mp_mode ? s.tx_hold[RXD_MP_BIT] : 1'b1,
                    s.tx_hold[7:0], 1'b0};
                n.tx_cnt = s.mp_mode ? FRAME_MP : FRAME_PLAIN;
            end
        end
        else if (s.tx_busy)
        begin
            step = s.sync_mode ? sclk_fall : (tick16 && s.tx_tick == TICK_LAST);
            if (!s.sync_mode && tick16)
                n.tx_tick = s.tx_tick + 4'h1;
            if (step)
            begin
                n.tx_shift = {1'b1, s.tx_shift[10:1]};
                n.tx_cnt = s.tx_cnt - 4'h1;
                if (s.tx_cnt == 4'h1)
                begin
                    n.tx_busy = 1'b0;
                    // Done only if software has nothing queued behind it
                    if (n.tx_empty)
                    begin
                        n.tx_end = 1'b1;
                        ev[IRQ_TXEND] = 1'b1;
                    end
                end
            end
        end

        // Receiver: 16x oversampling in async, clock rising edge in sync
        unique case (s.rx_state)
            RX_IDLE:
            begin
                n.rx_tick = '0;
                n.rx_cnt = '0;
                if (s.rx_en && s.sync_mode)
                    n.rx_state = RX_DATA;
                else if (s.rx_en && !s.rx_sync)
                    n.rx_state = RX_START;
            end
            RX_START:
            begin
                if (tick16)
                    n.rx_tick = s.rx_tick + 4'h1;
                // Recheck mid start bit to reject glitches
                if (tick16 && s.rx_tick == TICK_MID)
                begin
                    n.rx_tick = '0;
                    n.rx_state = s.rx_sync ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (!s.sync_mode && tick16)
                    n.rx_tick = s.rx_tick + 4'h1;
                if (s.sync_mode ? sclk_rise : (tick16 && s.rx_tick == TICK_LAST))
                begin
                    n.rx_shift = rx_next;
                    n.rx_cnt = s.rx_cnt + 4'h1;
                    if (s.rx_cnt == rx_last)
                    begin
                        n.rx_state = s.sync_mode ? RX_IDLE : RX_STOP;
                        frame_done = s.sync_mode;
                        frame_data = rx_next[8:1];
                    end
                end
            end
            RX_STOP:
            begin
                if (tick16)
                    n.rx_tick = s.rx_tick + 4'h1;
                if (tick16 && s.rx_tick == TICK_LAST)
                begin
                    n.rx_state = RX_IDLE;
                    frame_done = 1'b1;
                    frame_data = s.mp_mode ? s.rx_shift[7:0] : s.rx_shift[8:1];
                    frame_mp = s.mp_mode && s.rx_shift[RXD_MP_BIT];
                    frame_ferr = !s.rx_sync;
                end
            end
        endcase
        if (!s.rx_en)
            n.rx_state = RX_IDLE;

        // Frame completion and filtering
        if (frame_done && !(filt_act && !frame_mp))
        begin
            if (filt_act)
                n.filt = 1'b0;
            if (s.rx_full)
            begin
                n.overrun_err_flag = 1'b1;
                ev[IRQ_RXERR] = 1'b1;
            end
            else
            begin
                n.rx_data = {frame_mp, frame_data};
                n.rx_full = 1'b1;
                ev[IRQ_RXFULL] = 1'b1;
            end
            if (frame_ferr)
            begin
                n.framing_err_flag = 1'b1;
                ev[IRQ_RXERR] = 1'b1;
            end
        end
        n.irq_stat = n.irq_stat | ev;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.baud_div <= BAUD_RESET;
            s.tx_empty <= 1'b1;
            s.tx_shift <= '1;
            s.rx_meta <= 1'b1;
            s.rx_sync <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    filter_block_a: assert property (
        frame_done && filt_act && !frame_mp && !access |=>
        s.rx_full == $past(s.rx_full) && s.overrun_err_flag == $past(s.overrun_err_flag) && s.framing_err_flag == $past(s.framing_err_flag))
        else $error("filtered frame changed receive status");
    filter_clear_a: assert property (
        frame_done && filt_act && frame_mp && !access |=> !s.filt && (s.rx_full || s.overrun_err_flag))
        else $error("filter not released by marked frame");
    filter_gate_a: assert property (
        frame_done && (!s.mp_mode || s.sync_mode) && !s.rx_full && !access |=> s.rx_full)
        else $error("frame dropped while filter inactive");
    tx_end_irq_en_mask_a: assert property (
        s.irq_stat[IRQ_TXEND] && !s.tx_end_irq_en && ((s.irq_stat & s.irq_mask & ~IRQ_TXEND_MASK) == '0)
        |-> !irq)
        else $error("transmit end interrupt not masked");
    tx_end_irq_en_pass_a: assert property (
        s.irq_stat[IRQ_TXEND] && s.irq_mask[IRQ_TXEND] && s.tx_end_irq_en |-> irq)
        else $error("transmit end interrupt not raised");
    async_clk_a: assert property (
        !s.sync_mode && s.clk_sel != CKS_RSVD |->
        serial_clk_pin_oe == (s.clk_sel == CKS_INT_OUT))
        else $error("async clock pin drive wrong");
    ext_clk_a: assert property (
        s.clk_sel == CKS_EXT |-> !serial_clk_pin_oe)
        else $error("clock pin driven while external");
    sync_clk_a: assert property (
        s.sync_mode && s.clk_sel == CKS_INT |-> serial_clk_pin_oe)
        else $error("sync internal clock not driven");
    ctrl_write_a: assert property (
        access && pwrite && paddr == OFF_CTRL && !frame_done |=>
        {s.filt, s.tx_end_irq_en, s.clk_sel} == $past(ctrl_wr_field))
        else $error("control fields not at their bits");
    irq_vec_a: assert property (
        s.irq_stat[IRQ_RXFULL] && s.irq_mask[IRQ_RXFULL] |-> irq && irq_vector == IRQ_VECTOR)
        else $error("receive interrupt or vector wrong");
    tx_end_a: assert property (
        $rose(s.tx_end) |-> !s.tx_busy && s.tx_empty && txd)
        else $error("transmit end while data pending");

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import scm_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd;
    logic pin_in, pin_out, pin_oe, irq, ext_en, sl;
    logic [7:0] paddr, irq_vector, d, got;
    logic [31:0] pwdata, prdata, r;
    int errors = 0;
    int n_tests = 0;
    int ctrl_m;

    scm_serial_ctrl #(.ADDR_W(8)) u_scm_serial_ctrl (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .serial_clk_pin_in(pin_in),
        .serial_clk_pin_out(pin_out), .serial_clk_pin_oe(pin_oe), .irq(irq),
        .irq_vector(irq_vector));
    scm_remote_station u_scm_remote_station (.clk(clk), .rxd(rxd), .txd(txd),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_en(ext_en));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            $display("wrong value at %0t: %s", $time, m);
            errors++;
        end
    endtask

    // APB master: hold request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            chk(0, 1, "no ready");
        r = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog sized well past the expected run of about a thousand cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, ext_en} = '0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(32'h9ff8));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped place
        apb(0, OFF_CTRL, 0);
        chk(r, 0, "ctrl reset");
        chk(irq_vector, 8'h17, "vector");
        apb(0, 8'h40, 0);
        chk(r, 0, "unmapped read");
        chk(sl, 1, "unmapped error answer");
        $display("test reset done");
        // Clock source table, both modes, all codes
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 4; c++)
            begin
                ext_en <= (c == 2);
                apb(1, OFF_MODE, m);
                apb(1, OFF_CTRL, c);
                @(posedge clk);
                chk(pin_oe, m ? (c == 0) : (c == 1), "clock pin enable");
                if (m)
                    chk(pin_out, 1, "idle clock level");
                apb(0, OFF_CTRL, 0);
                chk(r, c, "ctrl readback");
            end
        ext_en <= 1'b0;
        apb(1, OFF_CTRL, 32'h0000000C);
        apb(0, OFF_CTRL, 0);
        chk(r, 32'h0000000C, "enable bits");
        $display("test clock select done");
        // Filter in multiprocessor async mode
        d = $urandom;
        ctrl_m = 32'h18;
        apb(1, OFF_MODE, 32'h00000002);
        apb(1, OFF_CTRL, ctrl_m);
        u_scm_remote_station.send(d, 1'b0, 1'b1);
        repeat (6) @(posedge clk);
        apb(0, OFF_STAT, 0);
        chk(r[STAT_RXFULL], 0, "filtered frame flagged");
        apb(0, OFF_CTRL, 0);
        chk(r, ctrl_m, "filter kept");
        u_scm_remote_station.send(d, 1'b1, 1'b1);
        repeat (6) @(posedge clk);
        ctrl_m = ctrl_m & 32'h7;
        ctrl_m = ctrl_m | 32'h10;
        apb(0, OFF_CTRL, 0);
        chk(r, ctrl_m, "filter not cleared");
        apb(0, OFF_STAT, 0);
        chk(r[STAT_RXFULL], 1, "no rx full");
        apb(0, OFF_RXD, 0);
        chk(r, {23'h0, 1'b1, d}, "rx data");
        // Filter ignored outside multiprocessor mode
        d = $urandom;
        apb(1, OFF_MODE, 0);
        apb(1, OFF_CTRL, 32'h18);
        u_scm_remote_station.send(d, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        apb(0, OFF_RXD, 0);
        chk(r[7:0], d, "frame dropped without mp mode");
        $display("test filter done");
        // Transmit end with interrupt enable off, then on
        d = $urandom;
        apb(1, OFF_IMASK, IRQ_TXEND_MASK);
        apb(1, OFF_CTRL, 32'h20);
        apb(0, OFF_ISTAT, 0);
        fork
            u_scm_remote_station.recv(got);
            apb(1, OFF_TXD, d);
        join
        chk(got, d, "tx frame");
        r = 0;
        for (int k = 0; k < 100 && !r[STAT_TXEND]; k++)
            apb(0, OFF_STAT, 0);
        chk(r[STAT_TXEND], 1, "no tx end");
        chk(irq, 0, "irq while masked");
        apb(1, OFF_CTRL, 32'h24);
        @(posedge clk);
        chk(irq, 1, "irq not raised");
        apb(0, OFF_ISTAT, 0);
        @(posedge clk);
        chk(irq, 0, "irq after clear");
        $display("test transmit end done");
        complete_run();
    end
endmodule
